// File: core/table_xor_exec.v
// Executor for table write, test-and-skip-if-zero and the two xor instructions, with an APB slave.
//
// Local design decisions: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`include "exec_map.vh"
module table_xor_exec (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata_ff,
  output reg pready_ff,
  output reg pslverr_ff,
  output reg hold_we_ff,
  output reg [2:0] hold_idx_ff
);
  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_EXEC1 = 3'h1;
  localparam [2:0] S_EXEC2 = 3'h2;
  localparam [2:0] S_DISCARD = 3'h3;

  localparam [2:0] C_NONE = 3'h0;
  localparam [2:0] C_TABLE_WR = 3'h1;
  localparam [2:0] C_TST = 3'h2;
  localparam [2:0] C_XORL = 3'h3;
  localparam [2:0] C_XORF = 3'h4;

  wire [1:0] phase;
  reg [2:0] state_ff;
  reg [2:0] cls_ff;
  reg [15:0] instr_ff;
  reg pend_ff;
  reg [7:0] wreg_ff;
  reg [20:0] tptr_ff;
  reg [7:0] tlat_ff;
  reg [3:0] bank_ff;
  reg [11:0] faddr_ff;
  reg [7:0] opnd_ff;
  reg [7:0] res_ff;
  reg zero_ff;
  reg neg_ff;
  reg illegal_ff;
  reg skip_ff;
  reg [1:0] cycles_ff;
  reg wr_ok_ff;
  reg [7:0] hold_ff [0:7];
  reg [7:0] dmem [0:4095];
  reg [31:0] nxt_rdata;
  reg nxt_err;

  wire apb_setup_done;
  wire apb_commit;
  wire busy;
  wire start;
  wire [11:0] eaddr;
  wire two_word;
  integer i;

  quad_phase_gen u_phase (
    .pclk(pclk),
    .presetn(presetn),
    .phase_ff(phase)
  );

  function [11:0] eff_addr;
    input acc;
    input [7:0] f;
    input [3:0] bank;
    begin
      if (acc) begin
        eff_addr = {bank, f};
      end else if (f[7]) begin
        eff_addr = {4'hf, f};
      end else begin
        eff_addr = {4'h0, f};
      end
    end
  endfunction

  function [2:0] classify;
    input [15:0] op;
    begin
      if (op[15:2] == `PAT_TABLE_WR) begin
        classify = C_TABLE_WR;
      end else if (op[15:9] == `PAT_TEST_SKIP) begin
        classify = C_TST;
      end else if (op[15:8] == `PAT_XOR_LIT) begin
        classify = C_XORL;
      end else if (op[15:10] == `PAT_XOR_REG) begin
        classify = C_XORF;
      end else begin
        classify = C_NONE;
      end
    end
  endfunction

  assign busy = pend_ff | (state_ff != S_IDLE);
  assign start = pend_ff & (state_ff == S_IDLE) & (phase == `PH_Q4);
  assign eaddr = eff_addr(instr_ff[8], instr_ff[7:0], bank_ff);
  assign two_word = (instr_ff[15:12] == `PAT_TWOWORD_A) | (instr_ff[15:10] == `PAT_TWOWORD_B);
  assign apb_setup_done = psel & penable & ~pready_ff;
  assign apb_commit = psel & penable & pready_ff & wr_ok_ff;

  // Decode reads and errors one cycle ahead so pready and prdata both leave flip-flops.
  always @* begin
    nxt_rdata = 32'h00000000;
    nxt_err = 1'b0;
    case (paddr)
      `OFS_INSTR: nxt_rdata = {16'h0000, instr_ff};
      `OFS_STATUS: begin
        nxt_rdata[`ST_BUSY] = busy;
        nxt_rdata[`ST_SKIP] = skip_ff;
        nxt_rdata[`ST_ZERO] = zero_ff;
        nxt_rdata[`ST_NEG] = neg_ff;
        nxt_rdata[`ST_ILLEGAL] = illegal_ff;
        nxt_rdata[`ST_CYC_HI:`ST_CYC_LO] = cycles_ff;
      end
      `OFS_WREG: nxt_rdata = {24'h000000, wreg_ff};
      `OFS_TPTR: nxt_rdata = {11'h000, tptr_ff};
      `OFS_TLAT: nxt_rdata = {24'h000000, tlat_ff};
      `OFS_BANK: nxt_rdata = {28'h0000000, bank_ff};
      `OFS_FADDR: nxt_rdata = {20'h00000, faddr_ff};
      `OFS_FDATA: nxt_rdata = {24'h000000, dmem[faddr_ff]};
      default: begin
        if (paddr >= `OFS_HOLD0 && paddr <= `OFS_HOLD7 && paddr[1:0] == 2'h0) begin
          nxt_rdata = {24'h000000, hold_ff[paddr[4:2]]};
          nxt_err = pwrite;
        end else begin
          nxt_err = 1'b1;
        end
      end
    endcase
    // Writes while an instruction runs would race the engine, so they are refused.
    if (pwrite && busy) begin
      nxt_err = 1'b1;
    end
    if (pwrite && paddr == `OFS_STATUS) begin
      nxt_err = 1'b1;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h00000000;
      wr_ok_ff <= 1'b0;
    end else begin
      pready_ff <= apb_setup_done;
      pslverr_ff <= apb_setup_done & nxt_err;
      wr_ok_ff <= apb_setup_done & pwrite & ~nxt_err;
      if (apb_setup_done && !pwrite) begin
        prdata_ff <= nxt_rdata;
      end
    end
  end

  // Data memory has no reset; software seeds it through the address/data window.
  always @(posedge pclk) begin
    if (apb_commit && paddr == `OFS_FDATA) begin
      dmem[faddr_ff] <= pwdata[7:0];
    end else if (state_ff == S_EXEC1 && cls_ff == C_XORF && phase == `PH_Q4 && instr_ff[9]) begin
      dmem[eaddr] <= res_ff;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= S_IDLE;
      cls_ff <= C_NONE;
      instr_ff <= 16'h0000;
      pend_ff <= 1'b0;
      wreg_ff <= `RST_BYTE;
      tptr_ff <= `RST_TPTR;
      tlat_ff <= `RST_BYTE;
      bank_ff <= `RST_BANK;
      faddr_ff <= 12'h000;
      opnd_ff <= `RST_BYTE;
      res_ff <= `RST_BYTE;
      zero_ff <= 1'b0;
      neg_ff <= 1'b0;
      illegal_ff <= 1'b0;
      skip_ff <= 1'b0;
      cycles_ff <= 2'h0;
      hold_we_ff <= 1'b0;
      hold_idx_ff <= 3'h0;
      for (i = 0; i < 8; i = i + 1) begin
        hold_ff[i] <= `RST_HOLD;
      end
    end else begin
      hold_we_ff <= 1'b0;
      if (apb_commit) begin
        case (paddr)
          `OFS_INSTR: begin
            instr_ff <= pwdata[15:0];
            pend_ff <= 1'b1;
          end
          `OFS_WREG: wreg_ff <= pwdata[7:0];
          `OFS_TPTR: tptr_ff <= pwdata[20:0];
          `OFS_TLAT: tlat_ff <= pwdata[7:0];
          `OFS_BANK: bank_ff <= pwdata[3:0];
          `OFS_FADDR: faddr_ff <= pwdata[11:0];
          default: begin
          end
        endcase
      end
      // New instructions begin on the Q1 boundary of the next instruction cycle.
      if (start) begin
        pend_ff <= 1'b0;
        cls_ff <= classify(instr_ff);
        if (skip_ff) begin
          state_ff <= S_DISCARD;
          skip_ff <= two_word;
          cycles_ff <= cycles_ff + 2'h1;
        end else begin
          state_ff <= S_EXEC1;
          illegal_ff <= (classify(instr_ff) == C_NONE);
          cycles_ff <= (classify(instr_ff) == C_TABLE_WR) ? 2'h2 : 2'h1;
        end
      end else begin
        case (state_ff)
          S_IDLE: begin
          end
          S_EXEC1: begin
            case (phase)
              `PH_Q1: begin
              end
              `PH_Q2: opnd_ff <= (cls_ff == C_XORL) ? instr_ff[7:0] : dmem[eaddr];
              `PH_Q3: begin
                res_ff <= wreg_ff ^ opnd_ff;
              end
              default: begin
                state_ff <= (cls_ff == C_TABLE_WR) ? S_EXEC2 : S_IDLE;
                if (cls_ff == C_XORL || cls_ff == C_XORF) begin
                  zero_ff <= (res_ff == 8'h00);
                  neg_ff <= res_ff[7];
                end
                if (cls_ff == C_XORL || (cls_ff == C_XORF && !instr_ff[9])) begin
                  wreg_ff <= res_ff;
                end
                if (cls_ff == C_TST) begin
                  skip_ff <= (opnd_ff == 8'h00);
                end
                if (cls_ff == C_TABLE_WR && instr_ff[1:0] == `TPTR_PREINC) begin
                  tptr_ff <= tptr_ff + 21'h000001;
                end
              end
            endcase
          end
          S_EXEC2: begin
            case (phase)
              `PH_Q2: opnd_ff <= tlat_ff;
              `PH_Q4: begin
                state_ff <= S_IDLE;
                hold_ff[tptr_ff[2:0]] <= opnd_ff;
                hold_we_ff <= 1'b1;
                hold_idx_ff <= tptr_ff[2:0];
                // holding slot in pointer bits 2:0
                if (instr_ff[1:0] == `TPTR_POSTINC) begin
                  tptr_ff <= tptr_ff + 21'h000001;
                end else if (instr_ff[1:0] == `TPTR_POSTDEC) begin
                  tptr_ff <= tptr_ff - 21'h000001;
                end
              end
              default: begin
              end
            endcase
          end
          S_DISCARD: begin
            if (phase == `PH_Q4) begin
              state_ff <= S_IDLE;
            end
          end
          default: state_ff <= S_IDLE;
        endcase
      end
    end
  end
endmodule // table_xor_exec

// File: common/exec_map.vh
// Register offsets, opcode patterns and reset values for the table-write / skip / xor executor.
`ifndef EXEC_MAP_VH
`define EXEC_MAP_VH

`define OFS_INSTR 8'h00
`define OFS_STATUS 8'h04
`define OFS_WREG 8'h08
`define OFS_TPTR 8'h0c
`define OFS_TLAT 8'h10
`define OFS_BANK 8'h14
`define OFS_FADDR 8'h18
`define OFS_FDATA 8'h1c
`define OFS_HOLD0 8'h20
`define OFS_HOLD7 8'h3c

`define ST_BUSY 0
`define ST_SKIP 1
`define ST_ZERO 2
`define ST_NEG 3
`define ST_ILLEGAL 4
`define ST_CYC_LO 8
`define ST_CYC_HI 9

`define PAT_TABLE_WR 14'h0003
`define PAT_TEST_SKIP 7'h33
`define PAT_XOR_LIT 8'h0a
`define PAT_XOR_REG 6'h06
`define PAT_TWOWORD_A 4'hc
`define PAT_TWOWORD_B 6'h3b

`define TPTR_NOCHG 2'h0
`define TPTR_POSTINC 2'h1
`define TPTR_POSTDEC 2'h2
`define TPTR_PREINC 2'h3

`define RST_HOLD 8'hff
`define RST_BYTE 8'h00
`define RST_TPTR 21'h000000
`define RST_BANK 4'h0

`define PH_Q1 2'h0
`define PH_Q2 2'h1
`define PH_Q3 2'h2
`define PH_Q4 2'h3

`endif

// File: core/quad_phase_gen.v
// Free-running four-phase instruction cycle generator, one phase per clock.
`timescale 1ns/1ps
`include "exec_map.vh"
module quad_phase_gen (
  input wire pclk,
  input wire presetn,
  output reg [1:0] phase_ff
);
  wire [1:0] nxt_phase;

  assign nxt_phase = phase_ff + 2'h1;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_ff <= `PH_Q1;
    end else begin
      phase_ff <= nxt_phase;
    end
  end
endmodule // quad_phase_gen

// File: bench/exec_sva.sv
// Assertions on the executor's bus and holding-register ports.
`timescale 1ns/1ps
`include "exec_map.vh"
module exec_sva (
  input logic pclk,
  input logic presetn,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [7:0] paddr,
  input logic [31:0] pwdata,
  input logic [31:0] prdata_ff,
  input logic pready_ff,
  input logic pslverr_ff,
  input logic hold_we_ff,
  input logic [2:0] hold_idx_ff
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  reg [3:0] since_ff;
  wire tbl_go = psel && penable && pready_ff && pwrite && !pslverr_ff && paddr == `OFS_INSTR
    && pwdata[15:2] == `PAT_TABLE_WR;
  // Saturates, so a long idle spell never looks like a fresh table write.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) since_ff <= 4'hf;
    else if (tbl_go) since_ff <= 4'h0;
    else if (since_ff != 4'hf) since_ff <= since_ff + 4'h1;
  end
  sequence s_wait;
    psel && penable && !pready_ff;
  endsequence
  sequence s_done;
    psel && penable && pready_ff;
  endsequence
  property p_one_wait; s_wait |=> pready_ff; endproperty
  a_one_wait: assert property (p_one_wait) else $error("ready late");
  property p_rdy_pulse; pready_ff |=> !pready_ff; endproperty
  a_rdy_pulse: assert property (p_rdy_pulse) else $error("ready too long");
  property p_rdy_req; pready_ff |-> psel && penable; endproperty
  a_rdy_req: assert property (p_rdy_req) else $error("ready without access");
  property p_err_rdy; pslverr_ff |-> pready_ff; endproperty
  a_err_rdy: assert property (p_err_rdy) else $error("error without ready");
  property p_ro_hold; s_done ##0 (pwrite && paddr >= `OFS_HOLD0 && paddr <= `OFS_HOLD7) |-> pslverr_ff; endproperty
  a_ro_hold: assert property (p_ro_hold) else $error("holding write accepted");
  property p_unmapped;
    s_done ##0 (paddr > `OFS_HOLD7 || paddr[1:0] != 2'h0) |-> pslverr_ff && (pwrite || prdata_ff == 32'h0);
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("bad address accepted");
  property p_we_pulse; hold_we_ff |=> !hold_we_ff; endproperty
  a_we_pulse: assert property (p_we_pulse) else $error("holding strobe too long");
  property p_idx_hold; $changed(hold_idx_ff) |-> hold_we_ff; endproperty
  a_idx_hold: assert property (p_idx_hold) else $error("index moved alone");
  // The start waits up to four clocks for the Q4 boundary, then eight clocks of execution follow.
  property p_we_cause; hold_we_ff |-> since_ff >= 4'h9 && since_ff <= 4'hc; endproperty
  a_we_cause: assert property (p_we_cause) else $error("holding strobe uncaused");
endmodule // exec_sva
bind table_xor_exec exec_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_ff(prdata_ff), .pready_ff(pready_ff),
  .pslverr_ff(pslverr_ff), .hold_we_ff(hold_we_ff), .hold_idx_ff(hold_idx_ff));

// File: bench/tb_top.sv
// Self-checking bench for the table-write, skip and xor executor.
`timescale 1ns/1ps
`include "exec_map.vh"
module tb_top;
  reg pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  reg [7:0] paddr = 8'h0;
  reg [31:0] pwdata = 32'h0, rs = 32'h21, rd, p, l, w, v, r, f, ad, bk;
  reg [1:0] nz;
  reg [64:0] ent;
  reg [64:0] exp_q[$];
  reg [2:0] idx_q[$];
  wire [31:0] prdata_ff;
  wire pready_ff, pslverr_ff, hold_we_ff;
  wire [2:0] hold_idx_ff;
  integer bad_count = 0, n_checks = 0, cyc = 0, i, j;
  table_xor_exec dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata_ff(prdata_ff), .pready_ff(pready_ff), .pslverr_ff(pslverr_ff),
    .hold_we_ff(hold_we_ff), .hold_idx_ff(hold_idx_ff));
  always #10 pclk = ~pclk;
  function logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction
  task chk(input string nm, input [31:0] e, input [31:0] s);
    n_checks = n_checks + 1;
    if (e !== s) begin
      bad_count = bad_count + 1;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  task results;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // The run needs well under a thousand cycles; the ceiling only catches a hang.
  always @(posedge pclk) begin
    cyc = cyc + 1;
    if (psel && penable && pready_ff === 1'b1) begin
      ent = exp_q.pop_front();
      chk("slverr", {31'h0, ent[64]}, {31'h0, pslverr_ff});
      if (!pwrite) chk("rdata", ent[31:0] & ent[63:32], prdata_ff & ent[63:32]);
    end
    if (hold_we_ff === 1'b1) chk("hold_idx", {29'h0, idx_q.pop_front()}, {29'h0, hold_idx_ff});
    if (cyc > 5000) begin
      bad_count = bad_count + 1;
      results();
    end
  end
  task xfer(input w, input [7:0] a, input [31:0] d, input er, input [31:0] m, input [31:0] e);
    exp_q.push_back({er, m, e});
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready_ff !== 1'b1) @(posedge pclk);
    rd = prdata_ff;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task wr(input [7:0] a, input [31:0] d, input er);
    xfer(1'b1, a, d, er, 32'h0, 32'h0);
  endtask
  task rdc(input [7:0] a, input [31:0] m, input [31:0] e);
    xfer(1'b0, a, 32'h0, 1'b0, m, e);
  endtask
  task idle;
    rd = 32'h1;
    for (j = 0; j < 30 && rd[`ST_BUSY]; j++) rdc(`OFS_STATUS, 32'h0, 32'h0);
    chk("busy", 32'h0, {31'h0, rd[`ST_BUSY]});
  endtask
  task run(input [15:0] op);
    wr(`OFS_INSTR, {16'h0, op}, 1'b0);
    idle();
  endtask
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc(`OFS_HOLD0, 32'hffffffff, 32'hff);
    rdc(`OFS_TPTR, 32'hffffffff, 32'h0);
    for (i = 0; i < 6; i++) begin
      w = rnd() & 32'hff;
      v = (i == 1) ? w : rnd() & 32'hff;
      f = (rnd() & 32'h7f) | (i == 5 ? 32'h80 : 32'h0);
      bk = 32'h1 | (rnd() & 32'h6);
      ad = i[1] ? {20'h0, bk[3:0], f[7:0]} : (f[7] ? 32'hf00 + f : f);
      r = w ^ v;
      nz = {r[7], r[7:0] == 8'h0};
      wr(`OFS_BANK, bk, 1'b0);
      wr(`OFS_FADDR, ad, 1'b0);
      wr(`OFS_FDATA, v, 1'b0);
      wr(`OFS_WREG, w, 1'b0);
      run(i < 2 ? {`PAT_XOR_LIT, v[7:0]} : {`PAT_XOR_REG, i[0], i[1], f[7:0]});
      rdc(`OFS_WREG, 32'hff, (i < 2 || !i[0]) ? r : w);
      rdc(`OFS_FDATA, 32'hff, (i > 1 && i[0]) ? r : v);
      rdc(`OFS_STATUS, 32'h30c, {22'h0, 2'h1, 4'h0, nz, 2'h0});
    end
    $display("xor test done");
    for (i = 0; i < 4; i++) begin
      p = (i == 1) ? 32'h1fffff : rnd() & 32'h1fffff;
      l = rnd() & 32'hff;
      wr(`OFS_TPTR, p, 1'b0);
      wr(`OFS_TLAT, l, 1'b0);
      r = (i == 3) ? p + 1 : p;
      idx_q.push_back(r[2:0]);
      run({`PAT_TABLE_WR, i[1:0]});
      v = (i == 0) ? p : (i == 2 ? p - 1 : p + 1);
      rdc(`OFS_TPTR, 32'h1fffff, v);
      rdc({3'h1, r[2:0], 2'h0}, 32'hff, l);
      rdc(`OFS_STATUS, 32'h30c, {22'h0, 2'h2, 4'h0, nz, 2'h0});
    end
    $display("table write test done");
    for (i = 0; i < 3; i++) begin
      wr(`OFS_WREG, 32'h5a, 1'b0);
      wr(`OFS_FADDR, 32'h10, 1'b0);
      wr(`OFS_FDATA, i == 0 ? 32'h3 : 32'h0, 1'b0);
      run({`PAT_TEST_SKIP, 1'b0, 8'h10});
      rdc(`OFS_STATUS, i == 0 ? 32'h30e : 32'he, {22'h0, 2'h1, 4'h0, nz, i != 0, 1'b0});
      if (i == 2) run(16'hc000);
      run({`PAT_XOR_LIT, 8'hff});
      if (i != 0) rdc(`OFS_STATUS, 32'h302, {22'h0, i[1:0] + 2'h1, 8'h0});
      run({`PAT_XOR_LIT, 8'h0f});
      rdc(`OFS_WREG, 32'hff, i == 0 ? 32'haa : 32'h55);
      // The last xor leaves N set after 0xaa and clear after 0x55, Z clear in both.
      nz = (i == 0) ? 2'h2 : 2'h0;
    end
    $display("skip test done");
    wr(`OFS_STATUS, 32'h0, 1'b1);
    wr(`OFS_HOLD7, 32'h0, 1'b1);
    xfer(1'b0, 8'h40, 32'h0, 1'b1, 32'hffffffff, 32'h0);
    xfer(1'b0, 8'h06, 32'h0, 1'b1, 32'hffffffff, 32'h0);
    idx_q.push_back(v[2:0]);
    wr(`OFS_INSTR, {`PAT_TABLE_WR, 2'h0}, 1'b0);
    wr(`OFS_INSTR, {`PAT_XOR_LIT, 8'hff}, 1'b1);
    idle();
    rdc(`OFS_WREG, 32'hff, 32'h55);
    run(16'hffff);
    rdc(`OFS_STATUS, 32'h310, 32'h110);
    $display("refusal test done");
    results();
  end
endmodule // tb_top
